//--- dv/ctrl_status_checker_properties.sv
/* Port checker for the control and status register bank.
 * Assumes a bind into the bank top; one clock, srst high. */
`timescale 1ns/10ps
`default_nettype none
module ctrl_status_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Register ports
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic seq_wr,
    input wire logic warm_reset_event,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    // Device outputs
    input wire logic driver_gate_pin,
    input wire logic bus_heartbeat_watchdog_run,
    input wire logic memory_identifier_poll_run,
    input wire logic [3:0] sequencer_trigger_pulse,
    input wire logic [3:0] sequencer_trigger_level,
    input wire logic all_rails_power_down
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic seen_r;
    logic tw;
    assign tw = host_wr && !seq_wr && host_addr == 8'h85;
    // Only a sequencer write can ever release the force-low gate
    always_ff @(posedge clock) begin
        seen_r <= !srst && (seen_r || seq_wr);
    end
    property p_gate; !seen_r |-> !driver_gate_pin; endproperty
    a_gate: assert property (p_gate) else $error("gate pin high while forced");
    property p_trig; tw |=> {sequencer_trigger_level, sequencer_trigger_pulse} == $past(host_wdata); endproperty
    a_trig: assert property (p_trig) else $error("trigger outputs wrong");
    property p_once; (|sequencer_trigger_pulse) && !host_wr && !seq_wr |=> sequencer_trigger_pulse == 4'h0; endproperty
    a_once: assert property (p_once) else $error("trigger pulse too long");
    property p_level; !host_wr && !seq_wr |=> $stable(sequencer_trigger_level); endproperty
    a_level: assert property (p_level) else $error("level trigger moved");
    property p_lowpw; !seq_wr |=> $stable(bus_heartbeat_watchdog_run); endproperty
    a_lowpw: assert property (p_lowpw) else $error("low power moved without sequencer");
    property p_pair; bus_heartbeat_watchdog_run == memory_identifier_poll_run; endproperty
    a_pair: assert property (p_pair) else $error("watchdog and polling differ");
    property p_stat; host_rd && host_addr == 8'h83 |=> host_rdata[7:4] == 4'h0; endproperty
    a_stat: assert property (p_stat) else $error("count upper bits set");
    property p_clr; host_rd && host_addr == 8'h84 |=> !host_rdata[4]; endproperty
    a_clr: assert property (p_clr) else $error("clear bit reads one");
    property p_down; all_rails_power_down |-> $past(warm_reset_event); endproperty
    a_down: assert property (p_down) else $error("power down without warm reset");
    c_pulse: cover property (|sequencer_trigger_pulse);
    c_gate: cover property (driver_gate_pin);
    c_down: cover property (all_rails_power_down);
endmodule
bind sequencer_control_status_regs ctrl_status_checker u_chk (
    .clock(clock), .srst(srst), .host_wr(host_wr), .host_rd(host_rd), .seq_wr(seq_wr),
    .warm_reset_event(warm_reset_event), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .driver_gate_pin(driver_gate_pin),
    .bus_heartbeat_watchdog_run(bus_heartbeat_watchdog_run),
    .memory_identifier_poll_run(memory_identifier_poll_run),
    .sequencer_trigger_pulse(sequencer_trigger_pulse),
    .sequencer_trigger_level(sequencer_trigger_level),
    .all_rails_power_down(all_rails_power_down));
`default_nettype wire

//--- dv/host_port_model.sv
/* Host processor side of the byte register port.
 * Assumes read data is loaded one cycle after the read edge. */
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
    // Clock
    input wire logic clock,
    // Register port
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_addr,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata
);
    initial begin
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_addr = 8'h00;
        host_wdata = 8'h00;
    end
    // Released lines flip so stale values are never mistaken for data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        host_wr <= 1'b1;
        host_addr <= a;
        host_wdata <= d;
        @(posedge clock);
        host_wr <= 1'b0;
        host_addr <= ~a;
        host_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        host_rd <= 1'b1;
        host_addr <= a;
        @(posedge clock);
        host_rd <= 1'b0;
        host_addr <= ~a;
        @(posedge clock) #1;
        d = host_rdata;
    endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
/* Self-checking bench for the register bank, one task per scenario.
 * Assumes the host model and the bound port checker. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ctrl_status_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic seq_wr = 1'b0;
    logic nvm_load = 1'b0;
    logic warm_reset_event = 1'b0;
    logic soc_lvl = 1'b1;
    logic main_lvl = 1'b0;
    logic [7:0] seq_addr = 8'h00;
    logic [7:0] seq_wdata = 8'h00;
    logic [3:0] nvm_thr = 4'h2;
    logic [3:0] nvm_conv = 4'h6;
    logic host_wr, host_rd, gate, wd_run, poll_run, sl1, sl2, down;
    logic [7:0] host_addr, host_wdata, host_rdata, spread;
    logic [3:0] pulse, level, conv;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    initial forever #12.5 clock = ~clock;
    host_port_model host_model (.clock(clock), .host_wr(host_wr), .host_rd(host_rd),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata));
    // Gate pin is looped back as its own pin level
    sequencer_control_status_regs DUT (.clock(clock), .srst(srst), .host_wr(host_wr),
        .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .seq_wr(seq_wr), .seq_addr(seq_addr), .seq_wdata(seq_wdata),
        .nvm_load(nvm_load), .nvm_recovery_threshold(nvm_thr), .nvm_converter_reset(nvm_conv),
        .soc_reset_pin_level(soc_lvl), .main_reset_pin_level(main_lvl),
        .driver_gate_pin_level(gate), .warm_reset_event(warm_reset_event),
        .driver_gate_pin(gate), .bus_heartbeat_watchdog_run(wd_run),
        .memory_identifier_poll_run(poll_run), .sequencer_trigger_pulse(pulse),
        .sequencer_trigger_level(level), .sleep_request_one(sl1), .sleep_request_two(sl2),
        .converter_logic_reset(conv), .spread_spectrum_setting(spread),
        .all_rails_power_down(down));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host_model.rd(a, d);
        chk(what, exp, d);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_model.wr(a, d);
        #1;
    endtask
    task automatic seq(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        seq_wr <= 1'b1;
        seq_addr <= a;
        seq_wdata <= d;
        @(posedge clock);
        seq_wr <= 1'b0;
        #1;
    endtask
    task automatic warm(input logic exp);
        @(posedge clock);
        warm_reset_event <= 1'b1;
        @(posedge clock);
        warm_reset_event <= 1'b0;
        #1;
        chk("power down", {7'h0, exp}, {7'h0, down});
    endtask
    task automatic t_reset();
        rdchk("status", OFS_DRIVER_ENABLE_STATUS, 8'h0C);
        for (int a = 8'h80; a <= 8'h88; a++) begin
            if (a != 8'h82) rdchk("reset value", a[7:0], 8'h00);
        end
        rdchk("unmapped", 8'h8F, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_lowpower();
        seq(OFS_DRIVER_ENABLE_STATUS, 8'h18);
        chk("watchdog", 8'h00, {7'h0, wd_run});
        chk("polling", 8'h00, {7'h0, poll_run});
        wr(OFS_DRIVER_ENABLE_STATUS, 8'h00);
        chk("host cannot wake", 8'h00, {7'h0, wd_run});
        seq(OFS_DRIVER_ENABLE_STATUS, 8'h08);
        chk("watchdog back", 8'h01, {7'h0, wd_run});
        $display("test lowpower done");
    endtask
    task automatic t_gate();
        wr(OFS_DRIVER_CONTROL, 8'h01);
        chk("gate locked", 8'h00, {7'h0, gate});
        rdchk("control refused", OFS_DRIVER_CONTROL, 8'h00);
        wr(OFS_DRIVER_ENABLE_STATUS, 8'hF0);
        rdchk("status host write", OFS_DRIVER_ENABLE_STATUS, 8'hEC);
        seq(OFS_DRIVER_ENABLE_STATUS, 8'h00);
        @(posedge clock);
        main_lvl <= 1'b1;
        soc_lvl <= 1'b0;
        wr(OFS_DRIVER_CONTROL, 8'h01);
        chk("gate free", 8'h01, {7'h0, gate});
        rdchk("pin levels", OFS_DRIVER_ENABLE_STATUS, 8'h03);
        seq(OFS_DRIVER_ENABLE_STATUS, 8'h08);
        chk("gate forced", 8'h00, {7'h0, gate});
        rdchk("pin levels forced", OFS_DRIVER_ENABLE_STATUS, 8'h0A);
        rdchk("control cleared", OFS_DRIVER_CONTROL, 8'h00);
        $display("test gate done");
    endtask
    task automatic t_trig();
        wr(OFS_HOST_SEQUENCER_TRIGGERS, 8'hA5);
        chk("trigger out", 8'hA5, {level, pulse});
        @(posedge clock) #1;
        chk("pulse ends", 8'hA0, {level, pulse});
        rdchk("trigger readback", OFS_HOST_SEQUENCER_TRIGGERS, 8'hA0);
        $display("test trigger done");
    endtask
    task automatic t_regs();
        wr(OFS_SLEEP_REQUEST_SHADOW, 8'h42);
        chk("sleep", 8'h02, {6'h0, sl2, sl1});
        wr(OFS_SLEEP_REQUEST_SHADOW, 8'h01);
        chk("sleep", 8'h01, {6'h0, sl2, sl1});
        wr(OFS_CONVERTER_LOGIC_RESET, 8'h39);
        chk("converter", 8'h09, {4'h0, conv});
        rdchk("converter readback", OFS_CONVERTER_LOGIC_RESET, 8'h39);
        @(posedge clock);
        nvm_load <= 1'b1;
        @(posedge clock);
        nvm_load <= 1'b0;
        #1;
        chk("converter default", 8'h06, {4'h0, conv});
        rdchk("threshold default", OFS_RECOVERY_COUNT_CONTROL, 8'h02);
        wr(OFS_SPREAD_SPECTRUM_CONTROL, 8'h5A);
        chk("spread", 8'h5A, spread);
        // Same-edge collision: the host write is dropped
        fork
            host_model.wr(OFS_SLEEP_REQUEST_SHADOW, 8'h02);
            seq(OFS_CONVERTER_LOGIC_RESET, 8'h0C);
        join
        chk("host dropped", 8'h01, {6'h0, sl2, sl1});
        chk("sequencer write", 8'h0C, {4'h0, conv});
        $display("test regs done");
    endtask
    task automatic t_recov();
        warm(1'b0);
        warm(1'b1);
        rdchk("count", OFS_RECOVERY_COUNT_STATUS, 8'h02);
        wr(OFS_RECOVERY_COUNT_CONTROL, 8'h13);
        rdchk("count cleared", OFS_RECOVERY_COUNT_STATUS, 8'h00);
        rdchk("clear self", OFS_RECOVERY_COUNT_CONTROL, 8'h03);
        warm(1'b0);
        warm(1'b0);
        warm(1'b1);
        wr(OFS_RECOVERY_COUNT_STATUS, 8'h0F);
        rdchk("count read only", OFS_RECOVERY_COUNT_STATUS, 8'h03);
        $display("test recovery done");
    endtask
    // Whole run needs about 120 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_lowpower();
        t_gate();
        t_trig();
        t_regs();
        t_recov();
        final_report();
    end
endmodule
`default_nettype wire

//--- hdl/ctrl_status_pkg.sv
/*
 * Constants for the sequencer control and status register bank:
 * byte offsets, field positions, reset values and widths.
 * Assumes 8-bit registers on a byte-wide internal register port.
 */
package ctrl_status_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int RECOV_W = 4;
    localparam int TRIG_PULSE_N = 4;
    localparam int TRIG_LEVEL_N = 4;
    localparam int CONV_N = 4;
    localparam int SLEEP_N = 2;

    // Offsets
    localparam logic [7:0] OFS_DRIVER_CONTROL = 8'h80;
    localparam logic [7:0] OFS_DRIVER_ENABLE_STATUS = 8'h82;
    localparam logic [7:0] OFS_RECOVERY_COUNT_STATUS = 8'h83;
    localparam logic [7:0] OFS_RECOVERY_COUNT_CONTROL = 8'h84;
    localparam logic [7:0] OFS_HOST_SEQUENCER_TRIGGERS = 8'h85;
    localparam logic [7:0] OFS_SLEEP_REQUEST_SHADOW = 8'h86;
    localparam logic [7:0] OFS_CONVERTER_LOGIC_RESET = 8'h87;
    localparam logic [7:0] OFS_SPREAD_SPECTRUM_CONTROL = 8'h88;

    // Field positions
    localparam int BIT_DRIVER_OUTPUT_CONTROL = 0;
    localparam int BIT_BUS_LOW_POWER_SELECT = 4;
    localparam int BIT_DRIVER_GATE_FORCE_LOW = 3;
    localparam int BIT_SOC_RESET_PIN_LEVEL = 2;
    localparam int BIT_MAIN_RESET_PIN_LEVEL = 1;
    localparam int BIT_DRIVER_GATE_PIN_LEVEL = 0;
    localparam int BIT_RECOVERY_COUNTER_CLEAR = 4;
    localparam int STAT_RSVD_LSB = 5;

    // Reset values
    localparam logic [7:0] RST_DRIVER_CONTROL = 8'h00;
    localparam logic [7:0] RST_DRIVER_ENABLE_STATUS = 8'h08;
    localparam logic [7:0] RST_RECOVERY_COUNT_CONTROL = 8'h00;
    localparam logic [7:0] RST_HOST_SEQUENCER_TRIGGERS = 8'h00;
    localparam logic [7:0] RST_SLEEP_REQUEST_SHADOW = 8'h00;
    localparam logic [7:0] RST_CONVERTER_LOGIC_RESET = 8'h00;
    localparam logic [7:0] RST_SPREAD_SPECTRUM_CONTROL = 8'h00;
    localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
    localparam logic [3:0] RECOV_ZERO = 4'h0;
    localparam logic [3:0] RECOV_ONE = 4'h1;
    localparam logic [3:0] RECOV_MAX = 4'hF;
endpackage

//--- hdl/recovery_counter_unit.sv
/*
 * Warm-reset recovery counter with clear and power-down threshold.
 * Assumes warm_reset and clear are single-cycle pulses on clock.
 */
`timescale 1ns/10ps
`default_nettype none
module recovery_counter_unit (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Bank side
    recovery_if.unit rif
);
    import ctrl_status_pkg::*;

    typedef struct packed {
        logic [RECOV_W-1:0] count;
        logic power_down;
    } unit_state_t;

    unit_state_t st_r;
    unit_state_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.power_down = 1'b0;
        // A warm reset in the clear cycle still counts
        if (rif.warm_reset) begin
            if (rif.clear) begin
                st_nxt.count = RECOV_ONE;
            end else if (st_r.count != RECOV_MAX) begin
                st_nxt.count = st_r.count + RECOV_ONE;
            end
            // Saturate so a long run of resets cannot wrap below threshold
            if (rif.threshold != RECOV_ZERO && st_nxt.count >= rif.threshold) begin
                st_nxt.power_down = 1'b1;
            end
        end else if (rif.clear) begin
            st_nxt.count = RECOV_ZERO;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rif.count = st_r.count;
    assign rif.power_down = st_r.power_down;
endmodule
`default_nettype wire

//--- hdl/recovery_if.sv
/*
 * Carrier between the register bank and the recovery counter unit.
 * Assumes both ends share one clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface recovery_if;
    import ctrl_status_pkg::*;
    logic warm_reset;
    logic clear;
    logic [RECOV_W-1:0] threshold;
    logic [RECOV_W-1:0] count;
    logic power_down;
    modport bank (output warm_reset, output clear, output threshold,
        input count, input power_down);
    modport unit (input warm_reset, input clear, input threshold,
        output count, output power_down);
endinterface
`default_nettype wire

//--- hdl/sequencer_control_status_regs.sv
/*
 * Control and status register bank: driver gating, pin level status,
 * recovery counter, sequencer triggers, sleep shadows, converter resets.
 * Assumes a byte-wide host port behind the serial front end and a
 * privileged write port from the on-chip sequencer, both on clock.
 */
`timescale 1ns/10ps
`default_nettype none
module sequencer_control_status_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Host register port
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [ctrl_status_pkg::ADDR_W-1:0] host_addr,
    input wire logic [ctrl_status_pkg::DATA_W-1:0] host_wdata,
    output logic [ctrl_status_pkg::DATA_W-1:0] host_rdata,
    // Sequencer register port
    input wire logic seq_wr,
    input wire logic [ctrl_status_pkg::ADDR_W-1:0] seq_addr,
    input wire logic [ctrl_status_pkg::DATA_W-1:0] seq_wdata,
    // Nonvolatile defaults
    input wire logic nvm_load,
    input wire logic [ctrl_status_pkg::RECOV_W-1:0] nvm_recovery_threshold,
    input wire logic [ctrl_status_pkg::CONV_N-1:0] nvm_converter_reset,
    // Pin levels
    input wire logic soc_reset_pin_level,
    input wire logic main_reset_pin_level,
    input wire logic driver_gate_pin_level,
    input wire logic warm_reset_event,
    // Outputs to pins and device logic
    output logic driver_gate_pin,
    output logic bus_heartbeat_watchdog_run,
    output logic memory_identifier_poll_run,
    output logic [ctrl_status_pkg::TRIG_PULSE_N-1:0] sequencer_trigger_pulse,
    output logic [ctrl_status_pkg::TRIG_LEVEL_N-1:0] sequencer_trigger_level,
    output logic sleep_request_one,
    output logic sleep_request_two,
    output logic [ctrl_status_pkg::CONV_N-1:0] converter_logic_reset,
    output logic [ctrl_status_pkg::DATA_W-1:0] spread_spectrum_setting,
    output logic all_rails_power_down
);
    import ctrl_status_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] drv_ctrl;
        logic [DATA_W-1:STAT_RSVD_LSB] stat_rsvd;
        logic low_power;
        logic force_low;
        logic [DATA_W-1:RECOV_W+1] recov_rsvd;
        logic [RECOV_W-1:0] threshold;
        logic [TRIG_LEVEL_N-1:0] trig_level;
        logic [TRIG_PULSE_N-1:0] trig_pulse;
        logic [DATA_W-1:0] sleep_shadow;
        logic [DATA_W-1:0] conv_reset;
        logic [DATA_W-1:0] spread;
        logic [DATA_W-1:0] rdata;
    } bank_state_t;

    bank_state_t st_r;
    bank_state_t st_nxt;
    recovery_if rif ();

    function automatic logic hit(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] ofs);
        hit = wr && (a == ofs);
    endfunction

    // Reset image of the bank, force-low set
    function automatic bank_state_t reset_image();
        bank_state_t r;
        r = '0;
        r.drv_ctrl = RST_DRIVER_CONTROL;
        r.force_low = RST_DRIVER_ENABLE_STATUS[BIT_DRIVER_GATE_FORCE_LOW];
        r.low_power = RST_DRIVER_ENABLE_STATUS[BIT_BUS_LOW_POWER_SELECT];
        r.sleep_shadow = RST_SLEEP_REQUEST_SHADOW;
        r.conv_reset = RST_CONVERTER_LOGIC_RESET;
        r.spread = RST_SPREAD_SPECTRUM_CONTROL;
        r.stat_rsvd = RST_DRIVER_ENABLE_STATUS[DATA_W-1:STAT_RSVD_LSB];
        r.recov_rsvd = RST_RECOVERY_COUNT_CONTROL[DATA_W-1:RECOV_W+1];
        r.threshold = RST_RECOVERY_COUNT_CONTROL[RECOV_W-1:0];
        r.trig_level = RST_HOST_SEQUENCER_TRIGGERS[DATA_W-1:TRIG_PULSE_N];
        r.trig_pulse = RST_HOST_SEQUENCER_TRIGGERS[TRIG_PULSE_N-1:0];
        r.rdata = RDATA_UNMAPPED;
        return r;
    endfunction

    logic [DATA_W-1:0] stat_byte;
    logic [DATA_W-1:0] wdata;
    logic [ADDR_W-1:0] waddr;
    logic wen;
    logic [DATA_W-1:0] rd_byte;
    // Per-register write selects, shared by both ports
    logic sel_drv_ctrl;
    logic sel_drv_stat;
    logic sel_recov_ctrl;
    logic sel_triggers;
    logic sel_sleep;
    logic sel_conv;
    logic sel_spread;

    // Live pin levels, never stored
    always_comb begin
        stat_byte = '0;
        stat_byte[DATA_W-1:STAT_RSVD_LSB] = st_r.stat_rsvd;
        stat_byte[BIT_BUS_LOW_POWER_SELECT] = st_r.low_power;
        stat_byte[BIT_DRIVER_GATE_FORCE_LOW] = st_r.force_low;
        stat_byte[BIT_SOC_RESET_PIN_LEVEL] = soc_reset_pin_level;
        stat_byte[BIT_MAIN_RESET_PIN_LEVEL] = main_reset_pin_level;
        stat_byte[BIT_DRIVER_GATE_PIN_LEVEL] = driver_gate_pin_level;
    end

    // Sequencer write wins a same-cycle collision with the host
    always_comb begin
        wen = 1'b0;
        waddr = host_addr;
        wdata = host_wdata;
        if (seq_wr) begin
            wen = 1'b1;
            waddr = seq_addr;
            wdata = seq_wdata;
        end else if (host_wr) begin
            wen = 1'b1;
        end
    end

    always_comb begin
        sel_drv_ctrl = hit(wen, waddr, OFS_DRIVER_CONTROL);
        sel_drv_stat = hit(wen, waddr, OFS_DRIVER_ENABLE_STATUS);
        sel_recov_ctrl = hit(wen, waddr, OFS_RECOVERY_COUNT_CONTROL);
        sel_triggers = hit(wen, waddr, OFS_HOST_SEQUENCER_TRIGGERS);
        sel_sleep = hit(wen, waddr, OFS_SLEEP_REQUEST_SHADOW);
        sel_conv = hit(wen, waddr, OFS_CONVERTER_LOGIC_RESET);
        sel_spread = hit(wen, waddr, OFS_SPREAD_SPECTRUM_CONTROL);
    end

    // Clear is a strobe into the counter unit, never stored in the bank
    always_comb begin
        rif.clear = 1'b0;
        if (sel_recov_ctrl) begin
            rif.clear = wdata[BIT_RECOVERY_COUNTER_CLEAR];
        end
    end

    // Addressed byte as a read would capture it; pin levels are live
    always_comb begin
        rd_byte = RDATA_UNMAPPED;
        case (host_addr)
            OFS_DRIVER_CONTROL: begin
                rd_byte = st_r.drv_ctrl;
            end
            OFS_DRIVER_ENABLE_STATUS: begin
                rd_byte = stat_byte;
            end
            OFS_RECOVERY_COUNT_STATUS: begin
                rd_byte = {{(DATA_W-RECOV_W){1'b0}}, rif.count};
            end
            OFS_RECOVERY_COUNT_CONTROL: begin
                rd_byte = {st_r.recov_rsvd, 1'b0, st_r.threshold};
            end
            OFS_HOST_SEQUENCER_TRIGGERS: begin
                rd_byte = {st_r.trig_level, st_r.trig_pulse};
            end
            OFS_SLEEP_REQUEST_SHADOW: begin
                rd_byte = st_r.sleep_shadow;
            end
            OFS_CONVERTER_LOGIC_RESET: begin
                rd_byte = st_r.conv_reset;
            end
            OFS_SPREAD_SPECTRUM_CONTROL: begin
                rd_byte = st_r.spread;
            end
            default: begin
                rd_byte = RDATA_UNMAPPED;
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.trig_pulse = '0;

        if (sel_drv_ctrl) begin
            st_nxt.drv_ctrl = wdata;
        end

        // Reserved bits are open to both ports
        if (sel_drv_stat) begin
            st_nxt.stat_rsvd = wdata[DATA_W-1:STAT_RSVD_LSB];
            if (seq_wr) begin
                st_nxt.low_power = wdata[BIT_BUS_LOW_POWER_SELECT];
                st_nxt.force_low = wdata[BIT_DRIVER_GATE_FORCE_LOW];
            end
        end

        // New threshold is judged at the next warm reset
        if (sel_recov_ctrl) begin
            st_nxt.recov_rsvd = wdata[DATA_W-1:RECOV_W+1];
            st_nxt.threshold = wdata[RECOV_W-1:0];
        end

        // A write while pulsing restarts the pulse
        if (sel_triggers) begin
            st_nxt.trig_level = wdata[DATA_W-1:TRIG_PULSE_N];
            st_nxt.trig_pulse = wdata[TRIG_PULSE_N-1:0];
        end

        if (sel_sleep) begin
            st_nxt.sleep_shadow = wdata;
        end

        if (sel_conv) begin
            st_nxt.conv_reset = wdata;
        end

        if (sel_spread) begin
            st_nxt.spread = wdata;
        end

        // Memory defaults overwrite a same-cycle write to the threshold and to converter reset bits 3:0
        if (nvm_load) begin
            st_nxt.threshold = nvm_recovery_threshold;
            st_nxt.conv_reset[CONV_N-1:0] = nvm_converter_reset;
        end

        // Held low, so a later force-low release cannot expose a stale 1
        if (st_nxt.force_low) begin
            st_nxt.drv_ctrl[BIT_DRIVER_OUTPUT_CONTROL] = 1'b0;
        end

        if (host_rd) begin
            st_nxt.rdata = rd_byte;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r <= reset_image();
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rif.warm_reset = warm_reset_event;
    assign rif.threshold = st_r.threshold;

    recovery_counter_unit u_recovery (
        .clock(clock),
        .srst(srst),
        .rif(rif.unit)
    );

    // Pin outputs
    assign driver_gate_pin = st_r.drv_ctrl[BIT_DRIVER_OUTPUT_CONTROL] && !st_r.force_low;
    assign bus_heartbeat_watchdog_run = !st_r.low_power;
    assign memory_identifier_poll_run = !st_r.low_power;

    // Sequencer program inputs
    assign sequencer_trigger_pulse = st_r.trig_pulse;
    assign sequencer_trigger_level = st_r.trig_level;
    assign sleep_request_one = st_r.sleep_shadow[0];
    assign sleep_request_two = st_r.sleep_shadow[1];

    // Converter and rail controls
    assign converter_logic_reset = st_r.conv_reset[CONV_N-1:0];
    assign spread_spectrum_setting = st_r.spread;
    assign all_rails_power_down = rif.power_down;

    // Read data holds until the next read strobe
    assign host_rdata = st_r.rdata;
endmodule
`default_nettype wire
